/* hdl/bank0_data_memory.sv */
/*
  Bank 0 data memory: pointers, table registers, general RAM,
  bit set/clear and indirect access. Read data is one cycle late.
  Assumes only one of wr_en, bit_set, bit_clr per cycle.
*/
`timescale 1ns/1ps
`include "pmseq_params.svh"

module bank0_data_memory (
  input  wire logic               core_clk,  // Instruction clock
  input  wire logic               rst_n,     // Async reset, active low
  input  wire pmseq_pkg::dm_req_t dm,        // Core access
  input  wire logic               tbl_wr_en, // Table result write
  input  wire logic [7:0]         tbl_dest,  // Low byte target
  input  wire logic [14:0]        tbl_word,  // Fetched table word
  output logic      [7:0]         rd_data_q, // Read data
  output logic      [7:0]         tpl_q,     // Table pointer low
  output logic      [7:0]         tph_q      // Table pointer high
);
  logic [7:0] ram_q [`RAM_BASE:`RAM_TOP];
  logic [7:0] mpa_q, mpb_q, trh_q;
  logic       bank_q;

  // Pointers aimed at an indirect slot give no access
  function automatic logic [8:0] resolve(input logic [7:0] a);
    if (a == `ADDR_IND_A) resolve = {mpa_q != `ADDR_IND_A && mpa_q != `ADDR_IND_B, mpa_q};
    else if (a == `ADDR_IND_B) resolve = {!bank_q && mpb_q != `ADDR_IND_A && mpb_q != `ADDR_IND_B, mpb_q};
    else resolve = {1'b1, a};
  endfunction

  function automatic logic [7:0] loc_val(input logic [8:0] r);
    loc_val = 8'h00;
    if (r[8] && r[7:0] >= `RAM_BASE) loc_val = ram_q[r[7:0]];
    else if (r[8]) begin
      case (r[7:0])
        `ADDR_MP_A: loc_val = mpa_q;
        `ADDR_MP_B: loc_val = mpb_q;
        `ADDR_BANK: loc_val = {7'h00, bank_q};
        `ADDR_TPL:  loc_val = tpl_q;
        `ADDR_TRH:  loc_val = trh_q;
        `ADDR_TPH:  loc_val = tph_q;
        default:    loc_val = 8'h00;
      endcase
    end
  endfunction

  wire [8:0] rd_r   = resolve(dm.rd_addr);
  wire [8:0] wr_r   = resolve(tbl_wr_en ? tbl_dest : dm.wr_addr);
  wire [7:0] mask   = 8'h01 << dm.bit_idx;
  wire [7:0] cur    = loc_val(wr_r);
  wire [7:0] wr_val = tbl_wr_en ? tbl_word[7:0] : dm.bit_set ? (cur | mask) :
                      dm.bit_clr ? (cur & ~mask) : dm.wr_data;
  wire       wr_go  = wr_r[8] & (tbl_wr_en | dm.wr_en | dm.bit_set | dm.bit_clr);

  // ==========================================================
  // Special registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mpa_q     <= `REG_RESET;
      mpb_q     <= `REG_RESET;
      bank_q    <= 1'b0;
      tpl_q     <= `REG_RESET;
      tph_q     <= `REG_RESET;
      trh_q     <= `REG_RESET;
      rd_data_q <= `REG_RESET;
    end else begin
      rd_data_q <= loc_val(rd_r);
      if (tbl_wr_en) trh_q <= {1'b0, tbl_word[14:8]};
      if (wr_go && wr_r[7:0] == `ADDR_MP_A) mpa_q <= wr_val;
      if (wr_go && wr_r[7:0] == `ADDR_MP_B) mpb_q <= wr_val;
      if (wr_go && wr_r[7:0] == `ADDR_BANK) bank_q <= wr_val[0];
      if (wr_go && wr_r[7:0] == `ADDR_TPL) tpl_q <= wr_val;
      if (wr_go && wr_r[7:0] == `ADDR_TPH) tph_q <= wr_val;
    end
  end

  // No reset: RAM contents are undefined after power-up
  always_ff @(posedge core_clk) begin
    if (wr_go && wr_r[7:0] >= `RAM_BASE) ram_q[wr_r[7:0]] <= wr_val;
  end

  chk_high_byte:  assert property (@(posedge core_clk) disable iff (!rst_n)
    tbl_wr_en |=> trh_q == {1'b0, $past(tbl_word[14:8])}) else $error("high byte not loaded");
  chk_reserved:   assert property (@(posedge core_clk) disable iff (!rst_n)
    dm.rd_addr > `ADDR_TRH && dm.rd_addr < `ADDR_TPH |=> rd_data_q == 8'h00) else $error("reserved nonzero");
  chk_self_ind:   assert property (@(posedge core_clk) disable iff (!rst_n)
    dm.rd_addr == `ADDR_IND_A && mpa_q == `ADDR_IND_A |=> rd_data_q == 8'h00) else $error("self indirect");
  chk_trh_locked: assert property (@(posedge core_clk) disable iff (!rst_n)
    !tbl_wr_en |=> trh_q == $past(trh_q)) else $error("high byte changed without table read");
endmodule

/* hdl/program_memory_stack_sequencer.sv */
/*
  Program-memory sequencer: program counter, 4096x15 program store,
  interrupt vectoring, table reads, return stack and bank 0 data memory.
  Assumes one clock per instruction cycle; commands, interrupt
  requests and enables come from core logic on the same clock.
*/
// How it works
// - Store is 4096x15, addressed by PC or table
// - Reset starts fetch at address 000H
// - Enabled USB request, stack not full: vector 004H
// - Enabled timer overflow, stack not full: vector 00CH
// - Option off: table page from PC bits 11:8
// - Option on: table page from high pointer 3:0
// - Last-page read forces page to all ones
// - Low byte to target, high seven bits held
// - Table pointers read/write at 07H and 1FH
// - Table reads take two cycles
// - Four-level stack, hidden from software
// - Call or interrupt pushes, returns pop PC
// - Reset leaves stack pointer at empty top
// - Full stack defers interrupt until a return
// - Call on full stack drops oldest entry
// - Unused locations below 20H read 00H
// - RAM at 20H to FFH read/write
// - Any bit settable or clearable individually
// - Every location but 00H and 02H reachable through first pointer; second needs bank bit 0
// - First pointer always targets bank 0
// - Self-pointing indirect reads 00H, writes nothing
`timescale 1ns/1ps
`include "pmseq_params.svh"

module program_memory_stack_sequencer (
  input  wire logic                 core_clk,     // Instruction clock, 100 MHz
  input  wire logic                 rst_n,        // Async chip reset, active low
  input  wire logic                 table_pointer_high_option,  // High table pointer option pin
  input  wire logic                 cmd_valid,    // Command offered
  input  wire pmseq_pkg::core_cmd_t cmd,          // Command
  output logic                      cmd_ready,    // Command accepted if offered this cycle
  input  wire logic                 usb_req,      // USB interrupt request
  input  wire logic                 usb_en,       // USB interrupt enable
  input  wire logic                 tmr_req,      // Timer overflow request
  input  wire logic                 tmr_en,       // Timer interrupt enable
  output logic                      usb_ack,      // USB vector taken
  output logic                      tmr_ack,      // Timer vector taken
  input  wire pmseq_pkg::dm_req_t   dm,           // Data-memory access
  output logic      [7:0]           dm_rd_data,   // Data-memory read data
  input  wire logic                 rom_wr_en,    // Program store load strobe
  input  wire logic [11:0]          rom_wr_addr,  // Program store load address
  input  wire logic [14:0]          rom_wr_data,  // Program store load word
  output logic      [11:0]          pc,           // Next fetch address
  output logic      [14:0]          instr,        // Last fetched word
  output logic                      stack_full    // Four return addresses held
);

  // ==========================================================
  // State
  pmseq_pkg::seq_state_t state_q, state_d;
  logic [14:0] rom_q [0:`ROM_WORDS-1];
  logic [11:0] pc_q, pc_d;
  logic [11:0] tbl_addr_q;
  logic [7:0]  tbl_dest_q;
  logic [14:0] instr_q;
  logic        usb_pend_q, tmr_pend_q;
  logic        opt_s1_q, opt_s2_q;
  logic [11:0] stk_top;
  logic [7:0]  tpl, tph;

  // Page source chosen by the option pin; top nibble of tph unused
  function automatic logic [11:0] tbl_addr(input logic last, input logic opt,
                                           input logic [11:0] p, input logic [7:0] lo,
                                           input logic [7:0] hi);
    if (last) tbl_addr = {`LAST_PAGE, lo};
    else if (opt) tbl_addr = {hi[3:0], lo};
    else tbl_addr = {p[11:8], lo};
  endfunction

  // ==========================================================
  // Decode
  wire in_run   = (state_q == pmseq_pkg::ST_RUN);
  wire take_usb = in_run & usb_pend_q & usb_en & ~stack_full;
  wire take_tmr = in_run & ~take_usb & tmr_pend_q & tmr_en & ~stack_full;
  wire go       = cmd_valid & cmd_ready;
  wire is_call  = go & (cmd.op == pmseq_pkg::OP_CALL);
  wire is_ret   = go & (cmd.op == pmseq_pkg::OP_RET || cmd.op == pmseq_pkg::OP_RETURN_FROM_INTERRUPT);
  wire is_tab   = go & (cmd.op == pmseq_pkg::OP_TAB_CUR || cmd.op == pmseq_pkg::OP_TAB_LAST);
  wire is_step  = go & (cmd.op == pmseq_pkg::OP_STEP);
  wire push     = take_usb | take_tmr | is_call;
  wire tbl_wr   = (state_q == pmseq_pkg::ST_TBL);
  wire [14:0] tbl_word = rom_q[tbl_addr_q];
  wire [11:0] tbl_next = tbl_addr(cmd.op == pmseq_pkg::OP_TAB_LAST, opt_s2_q, pc_q, tpl, tph);

  assign cmd_ready = in_run & ~take_usb & ~take_tmr;
  assign usb_ack   = take_usb;
  assign tmr_ack   = take_tmr;
  assign pc        = pc_q;
  assign instr     = instr_q;

  // ==========================================================
  // Next program counter and state
  always_comb begin
    pc_d    = pc_q;
    state_d = state_q;
    case (state_q)
      pmseq_pkg::ST_RUN: begin
        if (take_usb) begin
          pc_d    = `VEC_USB;
          state_d = pmseq_pkg::ST_XFER;
        end else if (take_tmr) begin
          pc_d    = `VEC_TIMER;
          state_d = pmseq_pkg::ST_XFER;
        end else if (go) begin
          case (cmd.op)
            pmseq_pkg::OP_STEP: begin
              pc_d = pc_q + 12'd1;
            end
            pmseq_pkg::OP_JUMP, pmseq_pkg::OP_CALL: begin
              pc_d    = cmd.target;
              state_d = pmseq_pkg::ST_XFER;
            end
            pmseq_pkg::OP_RET, pmseq_pkg::OP_RETURN_FROM_INTERRUPT: begin
              pc_d    = stk_top;
              state_d = pmseq_pkg::ST_XFER;
            end
            pmseq_pkg::OP_TAB_CUR, pmseq_pkg::OP_TAB_LAST: begin
              state_d = pmseq_pkg::ST_TBL;
            end
            default: begin
              state_d = pmseq_pkg::ST_RUN;
            end
          endcase
        end
      end
      pmseq_pkg::ST_XFER: begin
        state_d = pmseq_pkg::ST_RUN;
      end
      pmseq_pkg::ST_TBL: begin
        state_d = pmseq_pkg::ST_RUN;
      end
      default: begin
        state_d = pmseq_pkg::ST_RUN;
      end
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= pmseq_pkg::ST_RUN;
      pc_q    <= `VEC_RESET;
    end else begin
      state_q <= state_d;
      pc_q    <= pc_d;
    end
  end

  // Option pin is asynchronous to the core
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      opt_s1_q <= 1'b0;
      opt_s2_q <= 1'b0;
    end else begin
      opt_s1_q <= table_pointer_high_option;
      opt_s2_q <= opt_s1_q;
    end
  end

  // A new request wins over the acknowledge clearing it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      usb_pend_q <= 1'b0;
      tmr_pend_q <= 1'b0;
    end else begin
      usb_pend_q <= usb_req | (usb_pend_q & ~take_usb);
      tmr_pend_q <= tmr_req | (tmr_pend_q & ~take_tmr);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      instr_q    <= 15'h0000;
      tbl_addr_q <= 12'h000;
      tbl_dest_q <= 8'h00;
    end else begin
      if (is_step) instr_q <= rom_q[pc_q];
      if (is_tab) tbl_addr_q <= tbl_next;
      if (is_tab) tbl_dest_q <= cmd.dest;
    end
  end

  // Loaded once by the boot path; no reset on the array
  always_ff @(posedge core_clk) begin
    if (rom_wr_en) rom_q[rom_wr_addr] <= rom_wr_data;
  end

  // ==========================================================
  // Sub-blocks
  return_stack u_stack (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .push      (push),
    .pop       (is_ret),
    .push_data (pc_q),
    .top       (stk_top),
    .full      (stack_full)
  );

  bank0_data_memory u_dmem (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .dm        (dm),
    .tbl_wr_en (tbl_wr),
    .tbl_dest  (tbl_dest_q),
    .tbl_word  (tbl_word),
    .rd_data_q (dm_rd_data),
    .tpl_q     (tpl),
    .tph_q     (tph)
  );

  // ==========================================================
  // Checks
  sequence tab_start;
    is_tab;
  endsequence

  sequence tab_finish;
    tbl_wr ##1 in_run;
  endsequence

  chk_reset_vector: assert property (@(posedge core_clk)
    $rose(rst_n) |-> pc_q == `VEC_RESET) else $error("reset vector wrong");
  chk_usb_vector:   assert property (@(posedge core_clk) disable iff (!rst_n)
    usb_ack |=> pc_q == `VEC_USB && state_q == pmseq_pkg::ST_XFER) else $error("usb vector wrong");
  chk_tmr_vector:   assert property (@(posedge core_clk) disable iff (!rst_n)
    tmr_ack |=> pc_q == `VEC_TIMER) else $error("timer vector wrong");
  chk_full_defer:   assert property (@(posedge core_clk) disable iff (!rst_n)
    stack_full |-> !usb_ack && !tmr_ack) else $error("interrupt taken on full stack");
  chk_pend_held:    assert property (@(posedge core_clk) disable iff (!rst_n)
    usb_pend_q && !usb_ack |=> usb_pend_q) else $error("deferred request lost");
  chk_cur_page:     assert property (@(posedge core_clk) disable iff (!rst_n)
    is_tab && cmd.op == pmseq_pkg::OP_TAB_CUR && !opt_s2_q
    |=> tbl_addr_q == {$past(pc_q[11:8]), $past(tpl)}) else $error("current page wrong");
  chk_high_page:    assert property (@(posedge core_clk) disable iff (!rst_n)
    is_tab && cmd.op == pmseq_pkg::OP_TAB_CUR && opt_s2_q
    |=> tbl_addr_q == {$past(tph[3:0]), $past(tpl)}) else $error("high pointer page wrong");
  chk_last_page:    assert property (@(posedge core_clk) disable iff (!rst_n)
    is_tab && cmd.op == pmseq_pkg::OP_TAB_LAST |=> tbl_addr_q[11:8] == `LAST_PAGE) else $error("last page wrong");
  chk_table_two:    assert property (@(posedge core_clk) disable iff (!rst_n)
    tab_start |=> tab_finish) else $error("table read not two cycles");
  chk_call_push:    assert property (@(posedge core_clk) disable iff (!rst_n)
    is_call |=> pc_q == $past(cmd.target) && stk_top == $past(pc_q)) else $error("call push wrong");
  chk_ret_pop:      assert property (@(posedge core_clk) disable iff (!rst_n)
    is_ret |=> pc_q == $past(stk_top) ##1 in_run) else $error("return restore wrong");
endmodule

/* hdl/return_stack.sv */
/*
  Hidden four-level return-address stack, circular so a push when
  full drops the oldest entry.
  Assumes push and pop never arrive in the same cycle.
*/
`timescale 1ns/1ps
`include "pmseq_params.svh"

module return_stack (
  input  wire logic        core_clk,   // Instruction clock
  input  wire logic        rst_n,      // Async reset, active low
  input  wire logic        push,       // Store push_data
  input  wire logic        pop,        // Drop newest entry
  input  wire logic [11:0] push_data,  // Return address
  output logic      [11:0] top,        // Newest entry
  output logic             full        // Four entries held
);
  logic [11:0] ent_q [0:3];
  logic [1:0]  ptr_q;
  logic [2:0]  cnt_q;

  function automatic logic [1:0] wrap(input logic [1:0] p, input logic up);
    wrap = up ? p + 2'd1 : p - 2'd1;
  endfunction

  assign top  = ent_q[wrap(ptr_q, 1'b0)];
  assign full = (cnt_q == `STACK_DEPTH);

  // ==========================================================
  // Pointer and level count
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_q <= 2'd0;
      cnt_q <= 3'd0;
    end else if (push) begin
      ptr_q <= wrap(ptr_q, 1'b1);
      cnt_q <= full ? cnt_q : cnt_q + 3'd1;
    end else if (pop && cnt_q != 3'd0) begin
      ptr_q <= wrap(ptr_q, 1'b0);
      cnt_q <= cnt_q - 3'd1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      ent_q[ptr_q] <= push_data;
    end
  end

  chk_keep_four:   assert property (@(posedge core_clk) disable iff (!rst_n)
    full && push |=> full && top == $past(push_data)) else $error("full push lost newest");
  chk_pop_restore: assert property (@(posedge core_clk) disable iff (!rst_n)
    push ##1 pop |-> top == $past(push_data)) else $error("pop did not return pushed address");
endmodule

/* shared/pmseq_params.svh */
/*
  Constants for the program-memory sequencer: data-memory offsets,
  program vectors, sizes and reset values.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef PMSEQ_PARAMS_SVH
`define PMSEQ_PARAMS_SVH

// ==========================================================
// Program store
`define ROM_WORDS        4096
`define ROM_WIDTH        15
`define VEC_RESET        12'h000
`define VEC_USB          12'h004
`define VEC_TIMER        12'h00c
`define LAST_PAGE        4'hf

// ==========================================================
// Bank 0 data-memory locations
`define ADDR_IND_A       8'h00
`define ADDR_MP_A        8'h01
`define ADDR_IND_B       8'h02
`define ADDR_MP_B        8'h03
`define ADDR_BANK        8'h04
`define ADDR_TPL         8'h07
`define ADDR_TRH         8'h08
`define ADDR_TPH         8'h1f
`define RAM_BASE         8'h20
`define RAM_TOP          8'hff
`define REG_RESET        8'h00

// ==========================================================
// Stack and timing
`define STACK_DEPTH      3'd4
`define TABLE_CYCLES     2

`endif

/* shared/pmseq_pkg.sv */
/*
  Types shared by the sequencer and its data memory.
  Assumes pmseq_params.svh is on the include path.
*/
`include "pmseq_params.svh"

package pmseq_pkg;

  // ==========================================================
  // Core commands, one per instruction cycle
  typedef enum logic [2:0] {
    OP_STEP     = 3'h0,
    OP_JUMP     = 3'h1,
    OP_CALL     = 3'h2,
    OP_RET      = 3'h3,
    OP_RETURN_FROM_INTERRUPT     = 3'h4,
    OP_TAB_CUR  = 3'h5,
    OP_TAB_LAST = 3'h6
  } op_kind_t;

  typedef struct packed {
    op_kind_t    op;
    logic [11:0] target;
    logic [7:0]  dest;
  } core_cmd_t;

  typedef struct packed {
    logic [7:0] rd_addr;
    logic       wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic       bit_set;
    logic       bit_clr;
    logic [2:0] bit_idx;
  } dm_req_t;

  typedef enum logic [2:0] {
    ST_RUN  = 3'b001,
    ST_XFER = 3'b010,
    ST_TBL  = 3'b100
  } seq_state_t;

endpackage

/* sim/program_memory_stack_sequencer_tb.sv */
/*
  Self-checking bench for the program-memory sequencer: program store,
  table reads, data memory, return stack and interrupt vectoring.
  Assumes the design and pmseq_pkg are compiled first; inputs change on falling edges.
*/
`timescale 1ns/1ps
`include "pmseq_params.svh"

module program_memory_stack_sequencer_tb;
  logic                 core_clk, rst_n, table_pointer_high_option, cmd_valid, cmd_ready;
  logic                 usb_req, usb_en, tmr_req, tmr_en, usb_ack, tmr_ack;
  logic                 rom_wr_en, stack_full, rdy_after;
  pmseq_pkg::core_cmd_t cm;
  pmseq_pkg::dm_req_t   dmr;
  logic [7:0]           dm_rd_data;
  logic [11:0]          rom_wr_addr, pc, take_pc, pc_after;
  logic [14:0]          rom_wr_data, instr, ins_after;
  logic [11:0]          pushed [5];
  int                   bad_count, num_checks;

  program_memory_stack_sequencer uut (
    .core_clk(core_clk), .rst_n(rst_n), .table_pointer_high_option(table_pointer_high_option), .cmd_valid(cmd_valid),
    .cmd(cm), .cmd_ready(cmd_ready), .usb_req(usb_req), .usb_en(usb_en), .tmr_req(tmr_req),
    .tmr_en(tmr_en), .usb_ack(usb_ack), .tmr_ack(tmr_ack), .dm(dmr), .dm_rd_data(dm_rd_data),
    .rom_wr_en(rom_wr_en), .rom_wr_addr(rom_wr_addr), .rom_wr_data(rom_wr_data), .pc(pc),
    .instr(instr), .stack_full(stack_full));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ==========================================================
  // Reporting
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [14:0] exp, input logic [14:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ==========================================================
  // Access tasks
  task automatic rom_ld(input logic [11:0] a, input logic [14:0] w);
    rom_wr_en = 1'b1;
    rom_wr_addr = a;
    rom_wr_data = w;
    @(negedge core_clk);
    rom_wr_en = 1'b0;
    @(negedge core_clk);
  endtask

  // Kind 0 writes, 1 sets bit d[2:0], 2 clears it; idle cycle keeps strobes apart
  task automatic dm_op(input logic [1:0] kind, input logic [7:0] a, input logic [7:0] d);
    dmr.wr_addr = a;
    dmr.wr_data = d;
    dmr.bit_idx = d[2:0];
    dmr.wr_en = (kind == 2'd0);
    dmr.bit_set = (kind == 2'd1);
    dmr.bit_clr = (kind == 2'd2);
    @(negedge core_clk);
    {dmr.wr_en, dmr.bit_set, dmr.bit_clr} = 3'b000;
    @(negedge core_clk);
  endtask

  task automatic dm_chk(input logic [7:0] a, input logic [7:0] exp);
    dmr.rd_addr = a;
    @(negedge core_clk);
    chk("dm_rd_data", {7'h00, exp}, {7'h00, dm_rd_data});
  endtask

  // Waits for cmd_ready, offers the command for one cycle, then samples the cycle after the take
  task automatic issue(input pmseq_pkg::op_kind_t op, input logic [11:0] t, input logic [7:0] d);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1) begin
      @(negedge core_clk);
      n++;
      if (n > 20) begin
        bad_count++;
        $display("mismatch cmd_ready expected 1 seen %b", cmd_ready);
        test_done();
      end
    end
    cmd_valid = 1'b1;
    cm = '{op: op, target: t, dest: d};
    take_pc = pc;
    @(negedge core_clk);
    pc_after = pc;
    ins_after = instr;
    rdy_after = cmd_ready;
    cmd_valid = 1'b0;
    @(negedge core_clk);
  endtask

  task automatic wait_ack(input logic is_usb, input logic [11:0] vec);
    int n;
    logic [11:0] ret;
    n = 0;
    while ((is_usb ? usb_ack : tmr_ack) !== 1'b1) begin
      @(negedge core_clk);
      n++;
      if (n > 10) begin
        bad_count++;
        $display("mismatch interrupt ack expected 1 seen 0");
        test_done();
      end
    end
    ret = pc;
    @(negedge core_clk);
    chk("vector pc", {3'h0, vec}, {3'h0, pc});
    issue(pmseq_pkg::OP_RETURN_FROM_INTERRUPT, 12'h000, 8'h00);
    chk("return_from_interrupt pc", {3'h0, ret}, {3'h0, pc_after});
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    {rst_n, table_pointer_high_option, cmd_valid, usb_req, usb_en, tmr_req, tmr_en, rom_wr_en} = 8'h00;
    {rom_wr_addr, rom_wr_data} = '0;
    cm = '0;
    dmr = '0;
    bad_count = 0;
    num_checks = 0;
    repeat (10) @(negedge core_clk);
    chk("reset pc", 15'h0000, {3'h0, pc});
    chk("reset stack_full", 15'h0000, {14'h0000, stack_full});
    rst_n = 1'b1;
    rom_ld(12'h000, 15'h1234);
    rom_ld(12'h3a5, 15'h7f5a);
    rom_ld(12'h5a5, 15'h0c3e);
    rom_ld(12'hfa5, 15'h4321);
    issue(pmseq_pkg::OP_STEP, 12'h000, 8'h00);
    chk("fetch instr", 15'h1234, ins_after);
    chk("fetch pc", 15'h0001, {3'h0, pc_after});
    // Data memory map
    dm_op(2'd0, `RAM_BASE, 8'h5a);
    dm_op(2'd0, `RAM_TOP, 8'ha5);
    dm_chk(`RAM_BASE, 8'h5a);
    dm_chk(`RAM_TOP, 8'ha5);
    dm_op(2'd0, 8'h0c, 8'hff);
    dm_chk(8'h0c, 8'h00);
    dm_op(2'd0, `ADDR_TRH, 8'hff);
    dm_chk(`ADDR_TRH, 8'h00);
    dm_chk(`ADDR_TPL, 8'h00);
    dm_op(2'd0, `ADDR_TPL, 8'ha5);
    dm_op(2'd0, `ADDR_TPH, 8'he5);
    dm_chk(`ADDR_TPL, 8'ha5);
    dm_chk(`ADDR_TPH, 8'he5);
    dm_op(2'd1, `RAM_BASE, 8'h07);
    dm_op(2'd2, `RAM_BASE, 8'h01);
    dm_chk(`RAM_BASE, 8'hd8);
    dm_op(2'd0, `ADDR_MP_A, 8'h20);
    dm_chk(`ADDR_IND_A, 8'hd8);
    dm_op(2'd0, `ADDR_MP_B, 8'h21);
    dm_op(2'd0, `ADDR_IND_B, 8'h77);
    dm_chk(8'h21, 8'h77);
    dm_op(2'd0, `ADDR_BANK, 8'h01);
    dm_op(2'd0, `ADDR_IND_A, 8'h44);
    dm_chk(`RAM_BASE, 8'h44);
    dm_op(2'd0, `ADDR_BANK, 8'h00);
    dm_op(2'd0, `ADDR_MP_A, 8'h00);
    dm_op(2'd0, `ADDR_IND_A, 8'h55);
    dm_chk(`ADDR_IND_A, 8'h00);
    dm_chk(`ADDR_MP_A, 8'h00);
    // Table reads, interrupt enables held low throughout
    issue(pmseq_pkg::OP_JUMP, 12'h310, 8'h00);
    chk("jump pc", 15'h0310, {3'h0, pc_after});
    issue(pmseq_pkg::OP_TAB_CUR, 12'h000, 8'h21);
    chk("table ready", 15'h0000, {14'h0000, rdy_after});
    dm_chk(8'h21, 8'h5a);
    dm_chk(`ADDR_TRH, 8'h7f);
    table_pointer_high_option = 1'b1;
    repeat (3) @(negedge core_clk);
    issue(pmseq_pkg::OP_TAB_CUR, 12'h000, 8'h22);
    dm_chk(8'h22, 8'h3e);
    dm_chk(`ADDR_TRH, 8'h0c);
    issue(pmseq_pkg::OP_TAB_LAST, 12'h000, 8'h23);
    chk("table ready", 15'h0000, {14'h0000, rdy_after});
    dm_chk(8'h23, 8'h21);
    dm_chk(`ADDR_TRH, 8'h43);
    // Stack fill, overflow and deferred interrupt
    issue(pmseq_pkg::OP_JUMP, 12'h100, 8'h00);
    for (int i = 0; i < 5; i++) begin
      issue(pmseq_pkg::OP_CALL, 12'h200 + 12'(i) * 12'h100, 8'h00);
      pushed[i] = take_pc;
      chk("call pc", {3'h0, 12'h200 + 12'(i) * 12'h100}, {3'h0, pc_after});
      if (i == 2) chk("stack_full", 15'h0000, {14'h0000, stack_full});
    end
    chk("stack_full", 15'h0001, {14'h0000, stack_full});
    usb_en = 1'b1;
    usb_req = 1'b1;
    @(negedge core_clk);
    usb_req = 1'b0;
    repeat (6) begin
      chk("deferred usb_ack", 15'h0000, {14'h0000, usb_ack});
      @(negedge core_clk);
    end
    issue(pmseq_pkg::OP_RET, 12'h000, 8'h00);
    chk("ret pc", {3'h0, pushed[4]}, {3'h0, pc_after});
    wait_ack(1'b1, `VEC_USB);
    usb_en = 1'b0;
    for (int i = 3; i > 0; i--) begin
      issue(pmseq_pkg::OP_RET, 12'h000, 8'h00);
      chk("ret pc", {3'h0, pushed[i]}, {3'h0, pc_after});
    end
    tmr_en = 1'b1;
    tmr_req = 1'b1;
    @(negedge core_clk);
    tmr_req = 1'b0;
    wait_ack(1'b0, `VEC_TIMER);
    tmr_en = 1'b0;
    test_done();
  end

  initial begin
    #200000;
    bad_count++;
    $display("mismatch run time expected done seen hung");
    test_done();
  end
endmodule
